// [logic/sls_pkg.sv]
// Package for the serial lane status block
package sls_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_LANE_STATUS_REG = 8'h04;
    localparam logic [7:0] ADDR_DATA_LANE_STATUS_REG = 8'h08;
    localparam logic [7:0] ADDR_INIT = 8'h0c;
    localparam logic [7:0] ADDR_HS_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_SETTLE = 8'h14;
    localparam logic [7:0] ADDR_VERSION = 8'h18;
    // Field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SOFT_RESET_BIT = 1;
    localparam int CL_MODE_LSB = 1;
    localparam int CL_INIT_DONE_BIT = 3;
    localparam int CL_STOP_BIT = 4;
    localparam int DL_MODE_LSB = 1;
    localparam int DL_INIT_DONE_BIT = 3;
    localparam int DL_ABORT_BIT = 5;
    localparam int DL_STOP_BIT = 6;
    localparam int DL_PKT_LSB = 16;
    localparam logic [1:0] MODE_LP = 2'h0;
    localparam logic [1:0] MODE_HS = 2'h1;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [15:0] INIT_RESET = 16'h0190;
    localparam logic [15:0] HS_LIMIT_RESET = 16'hffff;
    localparam logic [7:0] SETTLE_RESET = 8'h0e;
    // Arbitrary version code
    localparam logic [31:0] VERSION_VALUE = 32'h0001_0000;
    // Timing: init unit is one microsecond
    localparam int CLK_MHZ = 20;
    localparam int INIT_UNIT_NS = 1000;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int INIT_UNIT_CYC = INIT_UNIT_NS / CLK_PERIOD_NS;
    localparam int LOCK_GAP_CYC = 4;
endpackage

// [logic/sls_lane_status.sv]
// Lane init, mode, packet counting and status registers over AXI4-Lite
`timescale 1ns/1ps
// Overview of operation
// - Report clock manager lock, then loop lock
// - Hold all lanes LP-11 through init
// - Receiver init about half to four fifths
// - Status bit 3 shows init done
// - Assert stop state when init completes
// - Stop in clock bit 4, data bit 6
// - Clock request starts high-speed clock
// - Clock mode reads 01 during HS
// - Receiver flags clock high-speed active
// - Data request allowed once clock runs
// - Data mode reads 01 during HS
// - Transmitter counts each data request once init is done
// - Receiver counts synced bursts and errors
// - Receiver flags invalid control sequences
// - Overrun flag when bytes exceed limit
// - Settle time writable, generation default
// - No lane-to-lane skew correction
// - Bus answers only out of reset, enabled
module sls_lane_status #(
    parameter bit IS_RX = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_mgr_lock_i,
    input wire logic pll_lock_i,
    input wire logic lane_enable_i,
    input wire logic cl_txrequesths_i,
    input wire logic dl_txrequesths_i,
    input wire logic [1:0] cl_line_i,
    input wire logic [1:0] dl_line_i,
    input wire logic cl_hs_detect_i,
    input wire logic dl_rxactivehs_i,
    input wire logic dl_rxsynchs_i,
    input wire logic dl_errsoths_i,
    input wire logic dl_errsotsynchs_i,
    input wire logic dl_byte_valid_i,
    input wire logic [1:0] dl_ctrl_state_i,
    output logic clk_mgr_lock_o,
    output logic pll_lock_o,
    output logic cl_stopstate_o,
    output logic dl_stopstate_o,
    output logic [1:0] cl_line_o,
    output logic [1:0] dl_line_o,
    output logic cl_hs_clk_en_o,
    output logic dl_hs_en_o,
    output logic rx_clock_active_indication_o,
    output logic dl_errcontrol_o,
    output logic [7:0] receiver_settle_time_o,
    input wire logic s_axi_aresetn_i,
    input wire logic s_axi_aclken_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    typedef enum logic [1:0] {
        SLS_WAIT_LOCK = 2'b00,
        SLS_INIT = 2'b01,
        SLS_STOP = 2'b11,
        SLS_HS = 2'b10
    } sls_lane_t;

    // Synchronisers for pin-side inputs
    logic [1:0] mmcm_sync_ff, pll_sync_ff, en_sync_ff;
    logic [1:0] clreq_sync_ff, dlreq_sync_ff, clhs_sync_ff;
    logic [1:0] act_sync_ff, sync_sync_ff, esot_sync_ff, esync_sync_ff, bv_sync_ff;
    logic [1:0] cl0_sync_ff, cl1_sync_ff, dl0_sync_ff, dl1_sync_ff;
    logic [1:0] cs0_sync_ff, cs1_sync_ff;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {mmcm_sync_ff, pll_sync_ff, en_sync_ff} <= 6'h00;
            {clreq_sync_ff, dlreq_sync_ff, clhs_sync_ff} <= 6'h00;
            {act_sync_ff, sync_sync_ff, esot_sync_ff, esync_sync_ff, bv_sync_ff} <= 10'h000;
            {cl0_sync_ff, cl1_sync_ff, dl0_sync_ff, dl1_sync_ff} <= 8'hff;
            {cs0_sync_ff, cs1_sync_ff} <= 4'h0;
        end else begin
            mmcm_sync_ff <= {mmcm_sync_ff[0], clk_mgr_lock_i};
            pll_sync_ff <= {pll_sync_ff[0], pll_lock_i};
            en_sync_ff <= {en_sync_ff[0], lane_enable_i};
            clreq_sync_ff <= {clreq_sync_ff[0], cl_txrequesths_i};
            dlreq_sync_ff <= {dlreq_sync_ff[0], dl_txrequesths_i};
            clhs_sync_ff <= {clhs_sync_ff[0], cl_hs_detect_i};
            act_sync_ff <= {act_sync_ff[0], dl_rxactivehs_i};
            sync_sync_ff <= {sync_sync_ff[0], dl_rxsynchs_i};
            esot_sync_ff <= {esot_sync_ff[0], dl_errsoths_i};
            esync_sync_ff <= {esync_sync_ff[0], dl_errsotsynchs_i};
            bv_sync_ff <= {bv_sync_ff[0], dl_byte_valid_i};
            cl0_sync_ff <= {cl0_sync_ff[0], cl_line_i[0]};
            cl1_sync_ff <= {cl1_sync_ff[0], cl_line_i[1]};
            dl0_sync_ff <= {dl0_sync_ff[0], dl_line_i[0]};
            dl1_sync_ff <= {dl1_sync_ff[0], dl_line_i[1]};
            cs0_sync_ff <= {cs0_sync_ff[0], dl_ctrl_state_i[0]};
            cs1_sync_ff <= {cs1_sync_ff[0], dl_ctrl_state_i[1]};
        end
    end
    wire logic mmcm_s = mmcm_sync_ff[1];
    wire logic pll_s = pll_sync_ff[1];
    wire logic en_s = en_sync_ff[1];
    wire logic clreq_s = clreq_sync_ff[1];
    wire logic dlreq_s = dlreq_sync_ff[1];
    wire logic clhs_s = clhs_sync_ff[1];
    wire logic act_s = act_sync_ff[1];
    wire logic [1:0] dl_ln_s = {dl1_sync_ff[1], dl0_sync_ff[1]};
    wire logic [1:0] cl_ln_s = {cl1_sync_ff[1], cl0_sync_ff[1]};
    wire logic [1:0] cs_s = {cs1_sync_ff[1], cs0_sync_ff[1]};

    // Registers
    logic [31:0] ctrl_ff;
    logic [15:0] init_ff, hs_limit_ff;
    logic [7:0] settle_ff;
    logic soft_rst;
    assign soft_rst = ctrl_ff[sls_pkg::CTRL_SOFT_RESET_BIT];

    // Lock reporting: pll lock never shown before clock manager lock
    logic [2:0] lock_gap_ff;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            clk_mgr_lock_o <= 1'b0;
            pll_lock_o <= 1'b0;
            lock_gap_ff <= 3'h0;
        end else begin
            clk_mgr_lock_o <= mmcm_s;
            if (!mmcm_s) begin
                lock_gap_ff <= 3'h0;
            end else if (lock_gap_ff != 3'(sls_pkg::LOCK_GAP_CYC)) begin
                lock_gap_ff <= lock_gap_ff + 3'h1;
            end
            pll_lock_o <= pll_s && clk_mgr_lock_o
                && lock_gap_ff == 3'(sls_pkg::LOCK_GAP_CYC);
        end
    end

    // Lane state machine; init length comes from a register so the
    // receiver can be set to part of the far transmitter's value
    sls_lane_t lane_ff;
    logic [15:0] unit_cnt_ff, init_cnt_ff;
    logic [15:0] byte_cnt_ff;
    logic init_done_ff, overrun_ff;
    logic go_ok;
    assign go_ok = en_s && !soft_rst && pll_lock_o;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lane_ff <= SLS_WAIT_LOCK;
            unit_cnt_ff <= 16'h0000;
            init_cnt_ff <= 16'h0000;
            init_done_ff <= 1'b0;
        end else if (!go_ok) begin
            lane_ff <= SLS_WAIT_LOCK;
            unit_cnt_ff <= 16'h0000;
            init_cnt_ff <= 16'h0000;
            init_done_ff <= 1'b0;
        end else begin
            unique case (lane_ff)
                SLS_WAIT_LOCK: begin
                    lane_ff <= SLS_INIT;
                end
                SLS_INIT: begin
                    if (unit_cnt_ff == 16'(sls_pkg::INIT_UNIT_CYC - 1)) begin
                        unit_cnt_ff <= 16'h0000;
                        init_cnt_ff <= init_cnt_ff + 16'h0001;
                    end else begin
                        unit_cnt_ff <= unit_cnt_ff + 16'h0001;
                    end
                    // Receiver only finishes if lines sat in LP-11 throughout
                    if (IS_RX && (cl_ln_s != 2'h3 || dl_ln_s != 2'h3)) begin
                        init_cnt_ff <= 16'h0000;
                    end else if (init_cnt_ff >= init_ff) begin
                        lane_ff <= SLS_STOP;
                        init_done_ff <= 1'b1;
                    end
                end
                SLS_STOP: begin
                    if (IS_RX ? (clhs_s || act_s) : clreq_s) begin
                        lane_ff <= SLS_HS;
                    end
                end
                SLS_HS: begin
                    if (IS_RX ? (!clhs_s && !act_s) : (!clreq_s && !dlreq_s)) begin
                        lane_ff <= SLS_STOP;
                    end
                end
            endcase
        end
    end

    logic cl_hs, dl_hs;
    assign cl_hs = lane_ff == SLS_HS && (IS_RX ? clhs_s : clreq_s);
    // Data only follows a running clock; early requests wait
    assign dl_hs = lane_ff == SLS_HS && cl_hs && (IS_RX ? act_s : dlreq_s);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cl_line_o <= 2'h3;
            dl_line_o <= 2'h3;
            cl_hs_clk_en_o <= 1'b0;
            dl_hs_en_o <= 1'b0;
            cl_stopstate_o <= 1'b0;
            dl_stopstate_o <= 1'b0;
            rx_clock_active_indication_o <= 1'b0;
        end else begin
            cl_line_o <= (!IS_RX && cl_hs) ? 2'h0 : 2'h3;
            dl_line_o <= (!IS_RX && dl_hs) ? 2'h0 : 2'h3;
            cl_hs_clk_en_o <= !IS_RX && cl_hs;
            dl_hs_en_o <= !IS_RX && dl_hs;
            cl_stopstate_o <= lane_ff == SLS_STOP || (lane_ff == SLS_HS && !cl_hs);
            dl_stopstate_o <= lane_ff == SLS_STOP || (lane_ff == SLS_HS && !dl_hs);
            rx_clock_active_indication_o <= IS_RX && cl_hs;
        end
    end

    // Packet count; bytes are passed per lane with no skew alignment
    logic [15:0] pkt_ff;
    logic dlreq_d_ff, act_d_ff, sync_seen_ff;
    logic burst_end;
    assign burst_end = act_d_ff && !act_s;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pkt_ff <= 16'h0000;
            dlreq_d_ff <= 1'b0;
            act_d_ff <= 1'b0;
            sync_seen_ff <= 1'b0;
        end else begin
            dlreq_d_ff <= dlreq_s;
            act_d_ff <= act_s;
            if (act_s && (sync_sync_ff[1] || esot_sync_ff[1] || esync_sync_ff[1])) begin
                sync_seen_ff <= 1'b1;
            end else if (burst_end) begin
                sync_seen_ff <= 1'b0;
            end
            if (!IS_RX && dlreq_s && !dlreq_d_ff && init_done_ff) begin
                pkt_ff <= pkt_ff + 16'h0001;
            end else if (IS_RX && burst_end && sync_seen_ff) begin
                pkt_ff <= pkt_ff + 16'h0001;
            end
        end
    end

    // Byte overrun and control error
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            byte_cnt_ff <= 16'h0000;
            overrun_ff <= 1'b0;
            dl_errcontrol_o <= 1'b0;
        end else begin
            if (!act_s) begin
                byte_cnt_ff <= 16'h0000;
            end else if (bv_sync_ff[1] && byte_cnt_ff != 16'hffff) begin
                byte_cnt_ff <= byte_cnt_ff + 16'h0001;
            end
            // Sticky until next burst starts
            if (IS_RX && act_s && byte_cnt_ff > hs_limit_ff) begin
                overrun_ff <= 1'b1;
            end else if (act_s && !act_d_ff) begin
                overrun_ff <= 1'b0;
            end
            // State 2'b11 marks an illegal LP line sequence from the detector
            dl_errcontrol_o <= IS_RX && cs_s == 2'h3;
        end
    end

    // AXI4-Lite slave, held idle without enable or in reset
    logic bus_go;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    assign bus_go = s_axi_aresetn_i && s_axi_aclken_i;
    assign s_axi_awready_o = bus_go && !aw_ff && !s_axi_bvalid_o;
    assign s_axi_wready_o = bus_go && !w_ff && !s_axi_bvalid_o;
    assign s_axi_arready_o = bus_go && !s_axi_rvalid_o;
    assign s_axi_rresp_o = 2'h0;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic wr_go;
    assign wr_go = aw_ff && w_ff && !s_axi_bvalid_o;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'h0;
            ctrl_ff <= sls_pkg::CTRL_RESET;
            init_ff <= sls_pkg::INIT_RESET;
            hs_limit_ff <= sls_pkg::HS_LIMIT_RESET;
            settle_ff <= sls_pkg::SETTLE_RESET;
        end else if (!s_axi_aresetn_i) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
        end else if (s_axi_aclken_i) begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata_i;
                wstrb_ff <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= 2'h0;
                unique case (awaddr_ff & 8'hfc)
                    sls_pkg::ADDR_CTRL: ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
                    sls_pkg::ADDR_INIT: init_ff <= 16'(merge({16'h0, init_ff}, wdata_ff, wstrb_ff));
                    sls_pkg::ADDR_HS_LIMIT: hs_limit_ff <= 16'(merge({16'h0, hs_limit_ff},
                                                                    wdata_ff, wstrb_ff));
                    sls_pkg::ADDR_SETTLE: settle_ff <= 8'(merge({24'h0, settle_ff},
                                                               wdata_ff, wstrb_ff));
                    sls_pkg::ADDR_CLOCK_LANE_STATUS_REG, sls_pkg::ADDR_DATA_LANE_STATUS_REG, sls_pkg::ADDR_VERSION: begin
                    end
                    default: s_axi_bresp_o <= 2'h2;
                endcase
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    logic [31:0] cl_stat, dl_stat;
    always_comb begin
        cl_stat = 32'h0000_0000;
        cl_stat[sls_pkg::CL_MODE_LSB +: 2] = cl_hs ? sls_pkg::MODE_HS : sls_pkg::MODE_LP;
        cl_stat[sls_pkg::CL_INIT_DONE_BIT] = init_done_ff;
        cl_stat[sls_pkg::CL_STOP_BIT] = cl_stopstate_o;
        dl_stat = 32'h0000_0000;
        dl_stat[sls_pkg::DL_MODE_LSB +: 2] = dl_hs ? sls_pkg::MODE_HS : sls_pkg::MODE_LP;
        dl_stat[sls_pkg::DL_INIT_DONE_BIT] = init_done_ff;
        dl_stat[sls_pkg::DL_ABORT_BIT] = overrun_ff;
        dl_stat[sls_pkg::DL_STOP_BIT] = dl_stopstate_o;
        dl_stat[sls_pkg::DL_PKT_LSB +: 16] = pkt_ff;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
        end else if (!s_axi_aresetn_i) begin
            s_axi_rvalid_o <= 1'b0;
        end else if (s_axi_aclken_i) begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                unique case (s_axi_araddr_i & 8'hfc)
                    sls_pkg::ADDR_CTRL: s_axi_rdata_o <= ctrl_ff;
                    sls_pkg::ADDR_CLOCK_LANE_STATUS_REG: s_axi_rdata_o <= cl_stat;
                    sls_pkg::ADDR_DATA_LANE_STATUS_REG: s_axi_rdata_o <= dl_stat;
                    sls_pkg::ADDR_INIT: s_axi_rdata_o <= {16'h0000, init_ff};
                    sls_pkg::ADDR_HS_LIMIT: s_axi_rdata_o <= {16'h0000, hs_limit_ff};
                    sls_pkg::ADDR_SETTLE: s_axi_rdata_o <= {24'h000000, settle_ff};
                    sls_pkg::ADDR_VERSION: s_axi_rdata_o <= sls_pkg::VERSION_VALUE;
                    default: s_axi_rdata_o <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
    assign receiver_settle_time_o = settle_ff;

    // Assertions
    a_lock_order: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        pll_lock_o |-> clk_mgr_lock_o) else $error("pll lock before clock lock");
    a_init_lp11: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        lane_ff == SLS_INIT |=> cl_line_o == 2'h3 && dl_line_o == 2'h3)
        else $error("lane left LP-11 in init");
    a_done_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        lane_ff == SLS_STOP |-> cl_stat[3] && dl_stat[3])
        else $error("init done bit clear");
    a_stop_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        lane_ff == SLS_STOP |=> cl_stopstate_o && dl_stopstate_o)
        else $error("stop state missing");
    a_stop_bits: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        cl_stat[4] == cl_stopstate_o && dl_stat[6] == dl_stopstate_o)
        else $error("stop bits wrong");
    a_cl_mode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        cl_hs |-> cl_stat[2:1] == 2'b01) else $error("clock mode wrong");
    a_dl_mode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        dl_hs |-> dl_stat[2:1] == 2'b01 && cl_hs) else $error("data mode wrong");
    a_rx_clk_act: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        IS_RX && cl_hs |=> rx_clock_active_indication_o)
        else $error("rx clock active missing");
    a_tx_count: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !IS_RX && dlreq_s && !dlreq_d_ff && init_done_ff |=> pkt_ff == $past(pkt_ff) + 16'h0001)
        else $error("tx packet not counted");
    a_bus_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !s_axi_aclken_i |-> !s_axi_awready_o && !s_axi_arready_o)
        else $error("bus ready while disabled");

endmodule // sls_lane_status

// [testbench/sls_peer_model.sv]
// Peer lane and lock source model for the lane status bench
`timescale 1ns/1ps
module sls_peer_model (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic clk_mgr_lock_o,
    output logic pll_lock_o,
    output logic lane_en_o,
    output logic [1:0] cl_line_o,
    output logic [1:0] dl_line_o
);
    logic [4:0] cnt_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 5'h00;
        end else if (cnt_ff != 5'h1f) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end
    // Clock manager settles first, loop some cycles later
    assign clk_mgr_lock_o = (cnt_ff >= 5'h08);
    assign pll_lock_o = (cnt_ff >= 5'h0c);
    assign lane_en_o = 1'b1;
    // Static LP-11, far beyond the minimum hold time
    assign cl_line_o = 2'h3;
    assign dl_line_o = 2'h3;
endmodule // sls_peer_model

// [testbench/sls_lane_status_tb_top.sv]
// Self-checking bench for the lane status block, receiver and transmitter
`timescale 1ns/1ps
module sls_lane_status_tb_top;
    logic clk = 1'b0, rst = 1'b1, arstn = 1'b0, acen = 1'b1, mlk, plk, len;
    logic [1:0] cll, dll, clo, dlo, br, rr, cst = 2'h0;
    logic hsd = 0, act = 0, syn = 0, es1 = 0, es2 = 0, bvi = 0;
    logic mlo, plo, cstop, dstop, cact, errc, awr, wr_o, bvo, arr, rvo;
    logic [7:0] settle, awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, d;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic creq = 0, dreq = 0, tds, tce, tde;
    logic [1:0] tcl, tdl;
    logic [31:0] tdat;
    int n_fail = 0, tests_run = 0;
    always #25 clk = ~clk;
    sls_peer_model peer (.clk_i(clk), .rst_i(rst), .clk_mgr_lock_o(mlk), .pll_lock_o(plk),
        .lane_en_o(len), .cl_line_o(cll), .dl_line_o(dll));
    sls_lane_status #(.IS_RX(1'b1)) dut (.ref_clk_i(clk), .reset_i(rst), .clk_mgr_lock_i(mlk),
        .pll_lock_i(plk), .lane_enable_i(len), .cl_txrequesths_i(1'b0), .dl_txrequesths_i(1'b0),
        .cl_line_i(cll), .dl_line_i(dll), .cl_hs_detect_i(hsd), .dl_rxactivehs_i(act),
        .dl_rxsynchs_i(syn), .dl_errsoths_i(es1), .dl_errsotsynchs_i(es2), .dl_byte_valid_i(bvi),
        .dl_ctrl_state_i(cst), .clk_mgr_lock_o(mlo), .pll_lock_o(plo), .cl_stopstate_o(cstop),
        .dl_stopstate_o(dstop), .cl_line_o(clo), .dl_line_o(dlo), .cl_hs_clk_en_o(),
        .dl_hs_en_o(), .rx_clock_active_indication_o(cact), .dl_errcontrol_o(errc),
        .receiver_settle_time_o(settle), .s_axi_aresetn_i(arstn), .s_axi_aclken_i(acen),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bvo), .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rvo),
        .s_axi_rready_i(rry));
    // Transmitter twin on the same bus answers in lockstep; only its read data is kept
    sls_lane_status #(.IS_RX(1'b0)) dut_tx (.ref_clk_i(clk), .reset_i(rst), .clk_mgr_lock_i(mlk),
        .pll_lock_i(plk), .lane_enable_i(len), .cl_txrequesths_i(creq), .dl_txrequesths_i(dreq),
        .cl_line_i(cll), .dl_line_i(dll), .cl_hs_detect_i(1'b0), .dl_rxactivehs_i(1'b0),
        .dl_rxsynchs_i(1'b0), .dl_errsoths_i(1'b0), .dl_errsotsynchs_i(1'b0),
        .dl_byte_valid_i(1'b0), .dl_ctrl_state_i(2'h0), .clk_mgr_lock_o(), .pll_lock_o(),
        .cl_stopstate_o(), .dl_stopstate_o(tds), .cl_line_o(tcl), .dl_line_o(tdl),
        .cl_hs_clk_en_o(tce), .dl_hs_en_o(tde), .rx_clock_active_indication_o(),
        .dl_errcontrol_o(), .receiver_settle_time_o(), .s_axi_aresetn_i(arstn),
        .s_axi_aclken_i(acen), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(),
        .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(), .s_axi_rdata_o(tdat), .s_axi_rresp_o(),
        .s_axi_rvalid_o(), .s_axi_rready_i(rry));
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Handshakes sampled at negedge, one edge ahead
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ah, wh, bh;
        awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            ah = awv & awr; wh = wv & wr_o; bh = bvo & bry; r = br;
            @(posedge clk);
            if (ah) awv <= 0;
            if (wh) wv <= 0;
            if (bh) begin
                bry <= 0;
                @(posedge clk);
                return;
            end
        end
        n_fail++;
        tally_and_finish;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic ah, rh;
        ara <= a; arv <= 1; rry <= 1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            ah = arv & arr; rh = rvo & rry; v = rdat;
            if (rh) chk(rr, 2'h0);
            @(posedge clk);
            if (ah) arv <= 0;
            if (rh) begin
                rry <= 0;
                @(posedge clk);
                return;
            end
        end
        n_fail++;
        tally_and_finish;
    endtask
    task automatic burst(input logic s, e1, e2, input int nb);
        chk(dstop, 1'b1);
        act <= 1; hsd <= 1; syn <= s; es1 <= e1; es2 <= e2;
        @(posedge clk);
        syn <= 0; es1 <= 0; es2 <= 0; bvi <= 1;
        repeat (nb) @(posedge clk);
        bvi <= 0;
        repeat (4) @(posedge clk);
        rd(sls_pkg::ADDR_DATA_LANE_STATUS_REG, d);
        chk(d[2:1], sls_pkg::MODE_HS);
        act <= 0; hsd <= 0;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_lock_init;
        logic [1:0] r;
        wr(sls_pkg::ADDR_INIT, 32'h2, r); // Short init keeps the run brief
        for (int k = 0; k < 9000 && !dstop; k++) begin
            @(negedge clk);
            if (plo && k < 200) chk(mlo, 1'b1);
            chk({clo, dlo}, 4'hf);
        end
        chk(cstop & dstop, 1'b1);
        @(posedge clk);
        rd(sls_pkg::ADDR_CLOCK_LANE_STATUS_REG, d);
        chk({d[4:3], d[2:1]}, {2'b11, sls_pkg::MODE_LP});
        rd(sls_pkg::ADDR_DATA_LANE_STATUS_REG, d);
        chk({d[6], d[3]}, 2'b11);
    endtask
    task automatic t_tx;
        for (int i = 1; i < 3; i++) begin
            chk(tds, 1'b1);
            creq <= 1;
            repeat (5) @(negedge clk);
            chk({tce, tcl}, 3'h4);
            @(posedge clk);
            dreq <= 1;
            repeat (5) @(negedge clk);
            chk({tde, tdl}, 3'h4);
            @(posedge clk);
            rd(sls_pkg::ADDR_CLOCK_LANE_STATUS_REG, d);
            chk(tdat[2:1], sls_pkg::MODE_HS);
            rd(sls_pkg::ADDR_DATA_LANE_STATUS_REG, d);
            chk({tdat[31:16], tdat[2:1]}, {16'(i), sls_pkg::MODE_HS});
            creq <= 0; dreq <= 0;
            repeat (6) @(posedge clk);
        end
    endtask
    task automatic t_levels;
        hsd <= 1; cst <= 2'h3;
        repeat (5) @(negedge clk);
        chk({cact, errc}, 2'b11);
        @(posedge clk);
        hsd <= 0; cst <= 2'h0;
        repeat (5) @(negedge clk);
        chk({cact, errc}, 2'b00);
        @(posedge clk);
    endtask
    task automatic t_packets;
        logic [1:0] r;
        burst(1, 0, 0, 1); burst(0, 1, 0, 1); burst(0, 0, 1, 1); burst(0, 0, 0, 1);
        rd(sls_pkg::ADDR_DATA_LANE_STATUS_REG, d);
        chk(d[31:16], 16'h0003);
        wr(sls_pkg::ADDR_HS_LIMIT, 32'h3, r);
        burst(1, 0, 0, 5);
        rd(sls_pkg::ADDR_DATA_LANE_STATUS_REG, d);
        chk(d[5], 1'b1);
        burst(1, 0, 0, 2);
        rd(sls_pkg::ADDR_DATA_LANE_STATUS_REG, d);
        chk(d[5], 1'b0);
    endtask
    task automatic t_bus;
        logic [1:0] r;
        rd(sls_pkg::ADDR_SETTLE, d);
        chk(d, {24'h0, sls_pkg::SETTLE_RESET});
        rd(sls_pkg::ADDR_HS_LIMIT, d);
        chk(d, 32'h3);
        wr(sls_pkg::ADDR_SETTLE, 32'h22, r);
        chk({r, settle}, {2'h0, 8'h22});
        wr(8'h40, 32'h5, r);
        chk(r, 2'h2);
        acen <= 0; ara <= sls_pkg::ADDR_SETTLE; arv <= 1;
        repeat (4) @(negedge clk);
        chk(arr, 1'b0);
        @(posedge clk);
        acen <= 1;
        rd(sls_pkg::ADDR_SETTLE, d);
        chk(d, 32'h22);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0; arstn <= 1;
        @(posedge clk);
        t_lock_init; t_tx; t_levels; t_packets; t_bus;
        tally_and_finish;
    end
endmodule // sls_lane_status_tb_top
